// >>> pkg/rssc_pkg.sv
package rssc_pkg;
    // ----------------------------------------
    // command codes and register offsets
    // ----------------------------------------
    localparam logic [7:0] CMD_WAKE = 8'h04;
    localparam logic [7:0] CMD_SLEEP = 8'h05;
    localparam logic [7:0] REG_SUPPLY_SETTINGS = 8'h07;
    localparam logic [7:0] CMD_CURRENT_SENSE = 8'h08;
    localparam logic [7:0] CMD_INSEL_FIRST = 8'h10;
    localparam logic [7:0] CMD_INSEL_LAST = 8'h1f;

    // ----------------------------------------
    // settings register layout
    // ----------------------------------------
    localparam int VOLTAGE_SELECT_BIT = 0;
    localparam int SLEEP_DISABLE_BIT = 1;
    localparam int SETTINGS_W = 2;
    localparam logic [1:0] SETTINGS_RST = 2'h0;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    // ----------------------------------------
    // serial link
    // ----------------------------------------
    // device address value is arbitrary
    localparam logic [6:0] DEV_ADDR = 7'h2a;
    localparam int BYTE_W = 8;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_READ_BIT = 4'h7;
    localparam int EVT_W = 9;
    localparam int EVT_DATA_BIT = 8;

    typedef enum logic [8:0] {
        LS_IDLE = 9'h001,
        LS_ADDR = 9'h002,
        LS_ADDR_ACK = 9'h004,
        LS_CMD = 9'h008,
        LS_CMD_ACK = 9'h010,
        LS_DATA = 9'h020,
        LS_DATA_ACK = 9'h040,
        LS_READ = 9'h080,
        LS_READ_ACK = 9'h100
    } rssc_link_state_t;
endpackage

// >>> core/rssc_sync.sv
`timescale 1ns/1ps
module rssc_sync #(
    parameter logic RST_VAL = 1'b1
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_pin,
    output logic o_level
);
    // ----------------------------------------
    // three stages, level moves once two agree
    // ----------------------------------------
    typedef struct packed {
        logic f1;
        logic f2;
        logic f3;
        logic lvl;
    } rssc_sync_st_t;

    rssc_sync_st_t s_r;
    rssc_sync_st_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.f1 = i_pin;
        s_nxt.f2 = s_r.f1;
        s_nxt.f3 = s_r.f2;
        if (s_r.f2 == s_r.f3) begin
            s_nxt.lvl = s_r.f3;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s_r <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_level = s_r.lvl;
endmodule

// >>> core/rssc_xfer.sv
`timescale 1ns/1ps
module rssc_xfer (
    input wire logic i_src_clk,
    input wire logic i_dst_clk,
    input wire logic i_rst,
    input wire logic i_go,
    input wire logic [rssc_pkg::EVT_W-1:0] i_data,
    output logic o_busy,
    output logic o_pulse,
    output logic [rssc_pkg::EVT_W-1:0] o_data
);
    // ----------------------------------------
    // source side: data held, request toggled
    // ----------------------------------------
    typedef struct packed {
        logic req;
        logic ack_m;
        logic ack_s;
        logic ack_t;
        logic [rssc_pkg::EVT_W-1:0] data;
    } rssc_src_st_t;

    typedef struct packed {
        logic req_m;
        logic req_s;
        logic req_t;
        logic ack;
        logic pulse;
        logic [rssc_pkg::EVT_W-1:0] data;
    } rssc_dst_st_t;

    rssc_src_st_t s_r;
    rssc_src_st_t s_nxt;
    rssc_dst_st_t d_r;
    rssc_dst_st_t d_nxt;

    assign o_busy = s_r.req != s_r.ack_t || s_r.ack_s != s_r.ack_t;

    always_comb begin
        s_nxt = s_r;
        s_nxt.ack_m = d_r.ack;
        s_nxt.ack_s = s_r.ack_m;
        s_nxt.ack_t = s_r.ack_s;
        if (i_go && !o_busy) begin
            s_nxt.req = !s_r.req;
            s_nxt.data = i_data;
        end
    end

    always_ff @(posedge i_src_clk or posedge i_rst) begin
        if (i_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------
    // destination side: capture on new toggle
    // ----------------------------------------
    always_comb begin
        d_nxt = d_r;
        d_nxt.req_m = s_r.req;
        d_nxt.req_s = d_r.req_m;
        d_nxt.req_t = d_r.req_s;
        d_nxt.pulse = 1'b0;
        if (d_r.req_s == d_r.req_t && d_r.req_t != d_r.ack) begin
            d_nxt.ack = d_r.req_t;
            d_nxt.data = s_r.data;
            d_nxt.pulse = 1'b1;
        end
    end

    always_ff @(posedge i_dst_clk or posedge i_rst) begin
        if (i_rst) begin
            d_r <= '0;
        end else begin
            d_r <= d_nxt;
        end
    end

    assign o_pulse = d_r.pulse;
    assign o_data = d_r.data;
endmodule

// >>> core/rssc_top.sv
`timescale 1ns/1ps
//
// Contract
// - after reset the regulator outputs the 3V level.
// - while awake the regulator is always enabled.
// - command 0x07 plus a data byte writes the settings; only the first data byte counts.
// - settings bit 0 picks 3V (0) or 2.65V (1).
// - settings bit 1 shuts the regulator off during sleep only.
// - acknowledge the command byte and every accepted data byte.
// - command 0x08 enters current-sense mode.
// - current-sense mode ends on any input select 0x10 to 0x1f.
// - command 0x05 enters sleep.
// - analog enable is low while asleep.
// - all register values survive sleep entry, residence and exit.
// - asleep, only 0x04 and 0x07 are acted on; others ignored.
// - command 0x04 leaves sleep.
// - after reset the device is awake.
// - reads are answered with retained values while asleep.
module rssc_top (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_link_clk,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_o,
    output logic o_sda_oe,
    output logic o_regulator_voltage_select,
    output logic o_regulator_enable,
    output logic o_analog_enable,
    output logic o_current_sense,
    output logic o_sleep
);
    // ----------------------------------------
    // link side state
    // ----------------------------------------
    typedef struct packed {
        rssc_pkg::rssc_link_state_t st;
        logic scl_q;
        logic sda_q;
        logic [rssc_pkg::BYTE_W-1:0] sh;
        logic [3:0] cnt;
        logic rw;
        logic mack;
        logic wr_set;
        logic [rssc_pkg::BYTE_W-1:0] ptr;
        logic [rssc_pkg::BYTE_W-1:0] shadow;
        logic oe;
        logic go;
        logic [rssc_pkg::EVT_W-1:0] evt;
    } rssc_link_st_t;

    // ----------------------------------------
    // core side state
    // ----------------------------------------
    typedef struct packed {
        logic sleep;
        logic sense;
        logic [rssc_pkg::SETTINGS_W-1:0] settings;
        logic pend;
        logic vsel;
        logic reg_en;
        logic ana_en;
    } rssc_core_st_t;

    rssc_link_st_t l_r;
    rssc_link_st_t l_nxt;
    rssc_core_st_t c_r;
    rssc_core_st_t c_nxt;

    logic scl_f;
    logic sda_f;
    logic xfer_busy;
    logic evt_pulse;
    logic [rssc_pkg::EVT_W-1:0] evt_word;
    logic start_cond;
    logic stop_cond;
    logic scl_rise;
    logic scl_fall;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [rssc_pkg::BYTE_W-1:0] read_value(
        input logic [rssc_pkg::BYTE_W-1:0] ptr,
        input logic [rssc_pkg::BYTE_W-1:0] shadow
    );
        logic [rssc_pkg::BYTE_W-1:0] v;
        v = rssc_pkg::READ_UNMAPPED;
        if (ptr == rssc_pkg::REG_SUPPLY_SETTINGS) begin
            v = shadow;
        end
        return v;
    endfunction

    function automatic logic [rssc_pkg::BYTE_W-1:0] settings_byte(
        input logic [rssc_pkg::BYTE_W-1:0] b
    );
        logic [rssc_pkg::BYTE_W-1:0] v;
        v = '0;
        v[rssc_pkg::SETTINGS_W-1:0] = b[rssc_pkg::SETTINGS_W-1:0];
        return v;
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    rssc_sync #(
        .RST_VAL(1'b1)
    ) u_sync_scl (
        .i_clk(i_link_clk),
        .i_rst(i_rst),
        .i_pin(i_scl),
        .o_level(scl_f)
    );

    rssc_sync #(
        .RST_VAL(1'b1)
    ) u_sync_sda (
        .i_clk(i_link_clk),
        .i_rst(i_rst),
        .i_pin(i_sda),
        .o_level(sda_f)
    );

    // ----------------------------------------
    // bus conditions
    // ----------------------------------------
    assign start_cond = l_r.scl_q && scl_f && l_r.sda_q && !sda_f;
    assign stop_cond = l_r.scl_q && scl_f && !l_r.sda_q && sda_f;
    assign scl_rise = !l_r.scl_q && scl_f;
    assign scl_fall = l_r.scl_q && !scl_f;

    // ----------------------------------------
    // serial slave
    // ----------------------------------------
    always_comb begin
        l_nxt = l_r;
        l_nxt.scl_q = scl_f;
        l_nxt.sda_q = sda_f;
        l_nxt.go = l_r.go && xfer_busy;
        if (start_cond) begin
            l_nxt.st = rssc_pkg::LS_ADDR;
            l_nxt.cnt = '0;
            l_nxt.oe = 1'b0;
        end else if (stop_cond) begin
            l_nxt.st = rssc_pkg::LS_IDLE;
            l_nxt.oe = 1'b0;
        end else begin
            case (l_r.st)
                rssc_pkg::LS_IDLE: begin
                    l_nxt.oe = 1'b0;
                end
                rssc_pkg::LS_ADDR: begin
                    if (scl_rise) begin
                        l_nxt.sh = {l_r.sh[6:0], sda_f};
                        l_nxt.cnt = l_r.cnt + 4'h1;
                    end else if (scl_fall &&
                                 l_r.cnt == rssc_pkg::BITS_PER_BYTE) begin
                        if (l_r.sh[7:1] == rssc_pkg::DEV_ADDR) begin
                            l_nxt.rw = l_r.sh[0];
                            l_nxt.oe = 1'b1;
                            l_nxt.st = rssc_pkg::LS_ADDR_ACK;
                        end else begin
                            l_nxt.st = rssc_pkg::LS_IDLE;
                        end
                    end
                end
                rssc_pkg::LS_ADDR_ACK: begin
                    if (scl_fall) begin
                        l_nxt.cnt = '0;
                        if (l_r.rw) begin
                            l_nxt.sh = read_value(l_r.ptr, l_r.shadow);
                            l_nxt.oe = !l_nxt.sh[7];
                            l_nxt.st = rssc_pkg::LS_READ;
                        end else begin
                            l_nxt.oe = 1'b0;
                            l_nxt.st = rssc_pkg::LS_CMD;
                        end
                    end
                end
                rssc_pkg::LS_CMD: begin
                    if (scl_rise) begin
                        l_nxt.sh = {l_r.sh[6:0], sda_f};
                        l_nxt.cnt = l_r.cnt + 4'h1;
                    end else if (scl_fall &&
                                 l_r.cnt == rssc_pkg::BITS_PER_BYTE) begin
                        l_nxt.oe = 1'b1;
                        l_nxt.ptr = l_r.sh;
                        l_nxt.wr_set = l_r.sh == rssc_pkg::REG_SUPPLY_SETTINGS;
                        l_nxt.evt = {1'b0, l_r.sh};
                        l_nxt.go = 1'b1;
                        l_nxt.st = rssc_pkg::LS_CMD_ACK;
                    end
                end
                rssc_pkg::LS_CMD_ACK: begin
                    if (scl_fall) begin
                        l_nxt.oe = 1'b0;
                        l_nxt.cnt = '0;
                        l_nxt.st = rssc_pkg::LS_DATA;
                    end
                end
                rssc_pkg::LS_DATA: begin
                    if (scl_rise) begin
                        l_nxt.sh = {l_r.sh[6:0], sda_f};
                        l_nxt.cnt = l_r.cnt + 4'h1;
                    end else if (scl_fall &&
                                 l_r.cnt == rssc_pkg::BITS_PER_BYTE) begin
                        l_nxt.oe = 1'b1;
                        l_nxt.evt = {1'b1, l_r.sh};
                        l_nxt.go = 1'b1;
                        l_nxt.wr_set = 1'b0;
                        if (l_r.wr_set) begin
                            l_nxt.shadow = settings_byte(l_r.sh);
                        end
                        l_nxt.st = rssc_pkg::LS_DATA_ACK;
                    end
                end
                rssc_pkg::LS_DATA_ACK: begin
                    if (scl_fall) begin
                        l_nxt.oe = 1'b0;
                        l_nxt.cnt = '0;
                        l_nxt.st = rssc_pkg::LS_DATA;
                    end
                end
                rssc_pkg::LS_READ: begin
                    if (scl_fall) begin
                        if (l_r.cnt == rssc_pkg::LAST_READ_BIT) begin
                            l_nxt.oe = 1'b0;
                            l_nxt.cnt = '0;
                            l_nxt.mack = 1'b0;
                            l_nxt.st = rssc_pkg::LS_READ_ACK;
                        end else begin
                            l_nxt.sh = {l_r.sh[6:0], 1'b0};
                            l_nxt.oe = !l_r.sh[6];
                            l_nxt.cnt = l_r.cnt + 4'h1;
                        end
                    end
                end
                rssc_pkg::LS_READ_ACK: begin
                    if (scl_rise) begin
                        l_nxt.mack = !sda_f;
                    end else if (scl_fall) begin
                        if (l_r.mack) begin
                            l_nxt.sh = read_value(l_r.ptr, l_r.shadow);
                            l_nxt.oe = !l_nxt.sh[7];
                            l_nxt.st = rssc_pkg::LS_READ;
                        end else begin
                            l_nxt.st = rssc_pkg::LS_IDLE;
                        end
                    end
                end
                default: begin
                    l_nxt.st = rssc_pkg::LS_IDLE;
                    l_nxt.oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_link_clk or posedge i_rst) begin
        if (i_rst) begin
            l_r <= '0;
            l_r.st <= rssc_pkg::LS_IDLE;
            l_r.scl_q <= 1'b1;
            l_r.sda_q <= 1'b1;
            l_r.shadow <= {6'h00, rssc_pkg::SETTINGS_RST};
        end else begin
            l_r <= l_nxt;
        end
    end

    assign o_sda_o = 1'b0;
    assign o_sda_oe = l_r.oe;

    // ----------------------------------------
    // byte events into the core clock
    // ----------------------------------------
    rssc_xfer u_xfer (
        .i_src_clk(i_link_clk),
        .i_dst_clk(i_clk),
        .i_rst(i_rst),
        .i_go(l_r.go),
        .i_data(l_r.evt),
        .o_busy(xfer_busy),
        .o_pulse(evt_pulse),
        .o_data(evt_word)
    );

    // ----------------------------------------
    // command interpreter
    // ----------------------------------------
    always_comb begin
        logic [rssc_pkg::BYTE_W-1:0] b;
        logic accept;
        b = evt_word[rssc_pkg::BYTE_W-1:0];
        accept = 1'b0;
        c_nxt = c_r;
        if (evt_pulse && !evt_word[rssc_pkg::EVT_DATA_BIT]) begin
            accept = !c_r.sleep ||
                     b == rssc_pkg::CMD_WAKE ||
                     b == rssc_pkg::REG_SUPPLY_SETTINGS;
            c_nxt.pend = accept && b == rssc_pkg::REG_SUPPLY_SETTINGS;
            if (accept) begin
                if (b == rssc_pkg::CMD_WAKE) begin
                    c_nxt.sleep = 1'b0;
                end
                if (b == rssc_pkg::CMD_SLEEP) begin
                    c_nxt.sleep = 1'b1;
                end
                if (b == rssc_pkg::CMD_CURRENT_SENSE) begin
                    c_nxt.sense = 1'b1;
                end
                if (b >= rssc_pkg::CMD_INSEL_FIRST &&
                    b <= rssc_pkg::CMD_INSEL_LAST) begin
                    c_nxt.sense = 1'b0;
                end
            end
        end else if (evt_pulse && c_r.pend) begin
            c_nxt.settings = b[rssc_pkg::SETTINGS_W-1:0];
            c_nxt.pend = 1'b0;
        end
        c_nxt.vsel = c_nxt.settings[rssc_pkg::VOLTAGE_SELECT_BIT];
        c_nxt.reg_en = !c_nxt.sleep ||
                       !c_nxt.settings[rssc_pkg::SLEEP_DISABLE_BIT];
        c_nxt.ana_en = !c_nxt.sleep;
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            c_r <= '0;
            c_r.sleep <= 1'b0;
            c_r.settings <= rssc_pkg::SETTINGS_RST;
            c_r.vsel <= 1'b0;
            c_r.reg_en <= 1'b1;
            c_r.ana_en <= 1'b1;
        end else begin
            c_r <= c_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign o_regulator_voltage_select = c_r.vsel;
    assign o_regulator_enable = c_r.reg_en;
    assign o_analog_enable = c_r.ana_en;
    assign o_current_sense = c_r.sense;
    assign o_sleep = c_r.sleep;
endmodule

// >>> bench/rssc_chk_sva.sv
`timescale 1ns/1ps
module rssc_chk_sva (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_link_clk,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic o_sda_o,
    input wire logic o_sda_oe,
    input wire logic o_regulator_voltage_select,
    input wire logic o_regulator_enable,
    input wire logic o_analog_enable,
    input wire logic o_current_sense,
    input wire logic o_sleep
);
    // ----------------------------------------
    // sleep transitions
    // ----------------------------------------
    sequence s_sleep_in;
        $rose(o_sleep);
    endsequence
    sequence s_sleep_out;
        $fell(o_sleep);
    endsequence

    // ----------------------------------------
    // core domain
    // ----------------------------------------
    chk_reset_state: assert property (
        @(posedge i_clk) disable iff (i_rst)
        $fell(i_rst) |-> !o_sleep && o_analog_enable &&
        !o_regulator_voltage_select && !o_current_sense)
        else $error("state after reset wrong");
    chk_awake_reg_on: assert property (
        @(posedge i_clk) disable iff (i_rst)
        !o_sleep |-> o_regulator_enable)
        else $error("regulator off while awake");
    chk_asleep_analog: assert property (
        @(posedge i_clk) disable iff (i_rst)
        o_sleep |-> !o_analog_enable)
        else $error("analog on while asleep");
    chk_awake_analog: assert property (
        @(posedge i_clk) disable iff (i_rst)
        !o_sleep |-> o_analog_enable)
        else $error("analog off while awake");
    chk_enter_keep: assert property (
        @(posedge i_clk) disable iff (i_rst)
        s_sleep_in |-> $stable(o_regulator_voltage_select) &&
        $stable(o_current_sense))
        else $error("settings changed on sleep entry");
    chk_exit_keep: assert property (
        @(posedge i_clk) disable iff (i_rst)
        s_sleep_out |-> $stable(o_regulator_voltage_select) &&
        $stable(o_current_sense) && o_regulator_enable && o_analog_enable)
        else $error("wake did not restore active state");

    // ----------------------------------------
    // link domain
    // ----------------------------------------
    chk_ack_hold: assert property (
        @(posedge i_link_clk) disable iff (i_rst)
        $rose(o_sda_oe) |-> o_sda_oe [*8])
        else $error("data pull too short");
    chk_oe_scl_low: assert property (
        @(posedge i_link_clk) disable iff (i_rst)
        $changed(o_sda_oe) |-> !i_scl)
        else $error("data pull changed with clock high");
endmodule

bind rssc_top rssc_chk_sva u_chk (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_link_clk(i_link_clk),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_sda_o(o_sda_o),
    .o_sda_oe(o_sda_oe),
    .o_regulator_voltage_select(o_regulator_voltage_select),
    .o_regulator_enable(o_regulator_enable),
    .o_analog_enable(o_analog_enable),
    .o_current_sense(o_current_sense),
    .o_sleep(o_sleep)
);

// >>> bench/rssc_host.sv
`timescale 1ns/1ps
module rssc_host (
    input wire logic i_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda
);
    // ----------------------------------------
    // bus idles high; a bit is three ticks
    // ----------------------------------------
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
    end
    task automatic tick;
        repeat (8) @(posedge i_clk);
        #1;
    endtask
    task automatic bit_io(input logic d, output logic s);
        o_sda = d;
        tick();
        o_scl = 1'b1;
        tick();
        s = i_sda;
        o_scl = 1'b0;
        tick();
    endtask
    task automatic start;
        o_sda = 1'b1;
        o_scl = 1'b1;
        tick();
        o_sda = 1'b0;
        tick();
        o_scl = 1'b0;
        tick();
    endtask
    task automatic stop;
        o_sda = 1'b0;
        tick();
        o_scl = 1'b1;
        tick();
        o_sda = 1'b1;
        tick();
    endtask
    task automatic byte_w(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], s);
        end
        bit_io(1'b1, s);
        ack = !s;
    endtask
    // ----------------------------------------
    // write: address, command, nd data bytes
    // ----------------------------------------
    task automatic wr(input logic [6:0] a, input logic [7:0] c, input int nd,
                      input logic [7:0] d, output int acks);
        logic k;
        acks = 0;
        start();
        byte_w({a, 1'b0}, k);
        if (k) begin
            acks++;
            byte_w(c, k);
            acks += int'(k);
            for (int n = 0; n < nd; n++) begin
                byte_w(n == 0 ? d : ~d, k);
                acks += int'(k);
            end
        end
        stop();
    endtask
    task automatic rd(output logic [7:0] b, output logic [7:0] b2);
        logic k;
        start();
        byte_w({rssc_pkg::DEV_ADDR, 1'b1}, k);
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, b[i]);
        end
        bit_io(1'b0, k);
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, b2[i]);
        end
        bit_io(1'b1, k);
        stop();
    endtask
endmodule

// >>> bench/regulator_sleep_sense_control_tb.sv
`timescale 1ns/1ps
module regulator_sleep_sense_control_tb;
    logic clk, lclk, rst, scl, sda_drv, sda_o, sda_oe;
    logic vsel, reg_en, ana_en, sense, sleep;
    wire sda;
    int n_mismatch, samples_checked, seed;
    int m_vsel, m_sdis, m_sleep, m_sense, m_ptr;
    logic [7:0] cmds [6] = '{8'h04, 8'h05, 8'h07, 8'h08, 8'h10, 8'h1f};
    logic [6:0] dev = rssc_pkg::DEV_ADDR;

    assign sda = sda_drv & (sda_oe ? sda_o : 1'b1);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        lclk = 1'b0;
        #1.7;
        forever #3 lclk = ~lclk;
    end

    rssc_top DUT (.i_clk(clk), .i_rst(rst), .i_link_clk(lclk), .i_scl(scl),
        .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
        .o_regulator_voltage_select(vsel), .o_regulator_enable(reg_en),
        .o_analog_enable(ana_en), .o_current_sense(sense), .o_sleep(sleep));
    rssc_host host (.i_clk(lclk), .i_sda(sda), .o_scl(scl), .o_sda(sda_drv));

    // ----------------------------------------
    // checking and closing
    // ----------------------------------------
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [7:0] seen,
                         input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic check_out;
        logic [4:0] e;
        int n;
        e = {m_vsel[0], ~m_sleep[0] | ~m_sdis[0], ~m_sleep[0], m_sense[0],
             m_sleep[0]};
        n = 0;
        while ({vsel, reg_en, ana_en, sense, sleep} !== e && n < 80) begin
            @(posedge clk);
            #1;
            n++;
        end
        if ({vsel, reg_en, ana_en, sense, sleep} !== e) begin
            n_mismatch++;
            $display("MISMATCH outputs exp %h seen %h", e,
                     {vsel, reg_en, ana_en, sense, sleep});
            report_and_stop();
        end
        check("voltage_select", 8'(vsel), 8'(e[4]));
        check("regulator_enable", 8'(reg_en), 8'(e[3]));
        check("analog_enable", 8'(ana_en), 8'(e[2]));
        check("current_sense", 8'(sense), 8'(e[1]));
        check("sleep", 8'(sleep), 8'(e[0]));
        check("sda_out", 8'(sda_o), 8'h00);
    endtask

    // ----------------------------------------
    // model and host operations
    // ----------------------------------------
    task automatic send(input logic [6:0] a, input logic [7:0] c,
                        input int nd, input logic [7:0] d);
        int acks;
        host.wr(a, c, nd, d, acks);
        check("acks", 8'(acks), a == dev ? 8'(nd + 2) : 8'h00);
        if (a == dev) begin
            m_ptr = c;
            if (m_sleep == 0 || c == 8'h04 || c == 8'h07) begin
                if (c == rssc_pkg::CMD_SLEEP) m_sleep = 1;
                if (c == rssc_pkg::CMD_WAKE) m_sleep = 0;
                if (c == rssc_pkg::CMD_CURRENT_SENSE) m_sense = 1;
                if (c >= 8'h10 && c <= 8'h1f) m_sense = 0;
                if (c == 8'h07 && nd > 0) begin
                    m_vsel = d[0];
                    m_sdis = d[1];
                end
            end
        end
        check_out();
    endtask
    task automatic rd_chk;
        logic [7:0] b, b2, e;
        host.rd(b, b2);
        e = m_ptr == 7 ? 8'(m_sdis * 2 + m_vsel) : 8'h00;
        check("readback", b, e);
        check("readback_again", b2, e);
    endtask
    task automatic do_reset;
        rst = 1'b1;
        {m_vsel, m_sdis, m_sleep, m_sense, m_ptr} = '0;
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        repeat (10) @(posedge clk);
        #1;
        check_out();
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        n_mismatch = 0;
        samples_checked = 0;
        seed = 24380;
        do_reset();
        $display("test reset done");
        send(dev, rssc_pkg::REG_SUPPLY_SETTINGS, 1, 8'h01);
        rd_chk();
        send(dev, rssc_pkg::REG_SUPPLY_SETTINGS, 2, 8'($random(seed)));
        rd_chk();
        send(dev ^ 7'h01, rssc_pkg::CMD_SLEEP, 0, 8'h00);
        $display("test settings done");
        for (int k = 0; k < 16; k++) begin
            send(dev, rssc_pkg::CMD_CURRENT_SENSE, 0, 8'h00);
            send(dev, k[0] ? 8'h0f : 8'h20 | 8'($random(seed) & 15), 1,
                 8'($random(seed)));
            send(dev, rssc_pkg::CMD_INSEL_FIRST + 8'(k), 0, 8'h00);
        end
        rd_chk();
        $display("test sense done");
        send(dev, rssc_pkg::CMD_CURRENT_SENSE, 0, 8'h00);
        send(dev, rssc_pkg::REG_SUPPLY_SETTINGS, 1, 8'h02);
        send(dev, rssc_pkg::CMD_SLEEP, 0, 8'h00);
        send(dev, 8'h12, 0, 8'h00);
        send(dev, rssc_pkg::REG_SUPPLY_SETTINGS, 1, 8'hfd);
        rd_chk();
        send(dev, rssc_pkg::CMD_WAKE, 0, 8'h00);
        send(dev, rssc_pkg::CMD_INSEL_LAST, 0, 8'h00);
        $display("test sleep done");
        for (int k = 0; k < 14; k++) begin
            send(dev, cmds[$unsigned($random(seed)) % 6], 1,
                 8'($random(seed)));
            rd_chk();
        end
        $display("test random done");
        send(dev, rssc_pkg::REG_SUPPLY_SETTINGS, 1, 8'h03);
        send(dev, rssc_pkg::CMD_SLEEP, 0, 8'h00);
        do_reset();
        $display("test second reset done");
        report_and_stop();
    end
endmodule
